// [logic/flacu_pkg.sv]
package flacu_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LAT_W = 2;
  localparam int CNT_W = 2;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ACCESS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_UNLOCK_KEY = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLASH_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TARGET_ADDRESS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_OPTION_BYTE_IMAGE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_WRITE_PROTECT_IMAGE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ECC_VALUE = 8'h24;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int AC_LAT_LSB = 0;
  localparam int AC_PREFETCH_ON_BIT = 4;
  localparam int AC_PREFETCH_ACTIVE_BIT = 5;
  localparam int CTRL_LOCK_BIT = 7;
  localparam logic [DATA_W-1:0] AC_RESET = 32'h0000_0030;
  localparam logic [DATA_W-1:0] AC_WRITABLE = 32'h0000_0013;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0080;
  localparam logic [DATA_W-1:0] CTRL_WRITABLE = 32'h0000_17F7;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_STEP = 32'h0000_0004;

  // ----------------------------------------
  // latency codes and wait counter values
  // ----------------------------------------
  localparam logic [LAT_W-1:0] LAT_ZERO_WAIT = 2'h0;
  localparam logic [LAT_W-1:0] LAT_ONE_WAIT = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;

  // arbitrary value, not tied to any part
  localparam logic [DATA_W-1:0] UNLOCK_KEY_DEFAULT = 32'h5A5A_1234;

  typedef enum logic [1:0] {
    FLACU_F_IDLE = 2'b00,
    FLACU_F_WAIT = 2'b01
  } flacu_fetch_t;

  typedef enum logic [1:0] {
    FLACU_H_IDLE = 2'b00,
    FLACU_H_REG = 2'b01,
    FLACU_H_FETCH = 2'b10
  } flacu_host_t;
endpackage

// [logic/flacu_if.sv]
`timescale 1ns/1ps
interface flacu_if;
  logic reg_sel;
  logic reg_wr;
  logic [flacu_pkg::ADDR_W-1:0] reg_addr;
  logic [flacu_pkg::DATA_W-1:0] reg_wdata;
  logic [flacu_pkg::DATA_W-1:0] reg_rdata;
  logic reg_ack;
  logic fetch_req;
  logic [flacu_pkg::DATA_W-1:0] fetch_addr;
  logic [flacu_pkg::DATA_W-1:0] fetch_rdata;
  logic fetch_ack;

  modport device (
    input reg_sel, reg_wr, reg_addr, reg_wdata, fetch_req, fetch_addr,
    output reg_rdata, reg_ack, fetch_rdata, fetch_ack
  );
  modport core (
    output reg_sel, reg_wr, reg_addr, reg_wdata, fetch_req, fetch_addr,
    input reg_rdata, reg_ack, fetch_rdata, fetch_ack
  );
endinterface

// [logic/flacu_core.sv]
`timescale 1ns/1ps
module flacu_core (
  input wire logic CLK,
  input wire logic SRST,
  flacu_if.core BUS,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_FETCH,
  input wire logic [flacu_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [flacu_pkg::DATA_W-1:0] CMD_WDATA,
  output logic CMD_READY,
  output logic [flacu_pkg::DATA_W-1:0] CMD_RDATA,
  output logic CMD_DONE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  flacu_pkg::flacu_host_t st_q, st_d;
  logic wr_q, wr_d;
  logic [flacu_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [flacu_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [flacu_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic [flacu_pkg::DATA_W-1:0] ac_val;

  always_comb begin
    ac_val = (CMD_WDATA & flacu_pkg::AC_WRITABLE) |
             (flacu_pkg::AC_RESET & ~flacu_pkg::AC_WRITABLE);
    if (CMD_WDATA[flacu_pkg::AC_LAT_LSB+1]) begin
      ac_val[flacu_pkg::AC_LAT_LSB +: flacu_pkg::LAT_W] =
        flacu_pkg::LAT_ONE_WAIT;
    end
  end

  always_comb begin
    st_d = st_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    case (st_q)
      flacu_pkg::FLACU_H_IDLE: begin
        if (CMD_VALID) begin
          wr_d = CMD_WRITE && !CMD_FETCH;
          addr_d = CMD_ADDR;
          wdata_d = CMD_WDATA;
          // reserved bits kept
          // fetches carry their address in wdata, so never mask those
          if (CMD_WRITE && !CMD_FETCH &&
              CMD_ADDR == flacu_pkg::OFF_ACCESS_CONTROL) begin
            wdata_d = ac_val;
          end
          st_d = CMD_FETCH ? flacu_pkg::FLACU_H_FETCH : flacu_pkg::FLACU_H_REG;
        end
      end
      flacu_pkg::FLACU_H_REG: begin
        if (BUS.reg_ack) begin
          rdata_d = BUS.reg_rdata;
          done_d = 1'b1;
          st_d = flacu_pkg::FLACU_H_IDLE;
        end
      end
      flacu_pkg::FLACU_H_FETCH: begin
        if (BUS.fetch_ack) begin
          rdata_d = BUS.fetch_rdata;
          done_d = 1'b1;
          st_d = flacu_pkg::FLACU_H_IDLE;
        end
      end
      default: st_d = flacu_pkg::FLACU_H_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= flacu_pkg::FLACU_H_IDLE;
      wr_q <= 1'b0;
      addr_q <= flacu_pkg::OFF_ACCESS_CONTROL;
      wdata_q <= flacu_pkg::ZERO_WORD;
      rdata_q <= flacu_pkg::ZERO_WORD;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------
  // bus drive
  // ----------------------------------------
  // requests stay up until the answer; the device drops ack next cycle
  assign BUS.reg_sel = (st_q == flacu_pkg::FLACU_H_REG) && !BUS.reg_ack;
  assign BUS.reg_wr = wr_q;
  assign BUS.reg_addr = addr_q;
  assign BUS.reg_wdata = wdata_q;
  assign BUS.fetch_req = (st_q == flacu_pkg::FLACU_H_FETCH) && !BUS.fetch_ack;
  assign BUS.fetch_addr = wdata_q;
  assign CMD_READY = (st_q == flacu_pkg::FLACU_H_IDLE);
  assign CMD_RDATA = rdata_q;
  assign CMD_DONE = done_q;
endmodule

// [logic/flacu_dev.sv]
`timescale 1ns/1ps
// How it works
// - two-bit latency sets wait cycles per access
// - code 00: no wait, core clock <=24MHz
// - code 01: one wait, up to 48MHz
// - bit 4 switches prefetch buffer on/off
// - read-only bit 5 shows prefetch actually active
// - access control resets with prefetch on, latency 0
// - key write releases the control lock bit
// - key register write-only, reads carry no meaning
// - software keeps reserved bits at reset values
// - control register resets with only lock set
module flacu_dev #(
  parameter logic [flacu_pkg::DATA_W-1:0] UNLOCK_KEY_VALUE =
    flacu_pkg::UNLOCK_KEY_DEFAULT
) (
  input wire logic CLK,
  input wire logic SRST,
  flacu_if.device BUS,
  input wire logic [flacu_pkg::DATA_W-1:0] FLASH_RDATA,
  input wire logic [flacu_pkg::DATA_W-1:0] OPTION_BYTE_IN,
  input wire logic [flacu_pkg::DATA_W-1:0] WRITE_PROTECT_IN,
  input wire logic [flacu_pkg::DATA_W-1:0] ECC_IN,
  output logic [flacu_pkg::DATA_W-1:0] FLASH_ADDR,
  output logic [flacu_pkg::DATA_W-1:0] CTRL_FIELDS,
  output logic LOCKED,
  output logic PREFETCH_ACTIVE
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [flacu_pkg::LAT_W-1:0] lat_q, lat_d;
  logic prefetch_on_q, prefetch_on_d;
  logic prefetch_active_flag_q, prefetch_active_flag_d;
  logic [flacu_pkg::DATA_W-1:0] ctrl_q, ctrl_d;
  logic [flacu_pkg::DATA_W-1:0] taddr_q, taddr_d;
  logic [flacu_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic wr_en;

  assign wr_en = BUS.reg_sel && BUS.reg_wr && !ack_q;

  // ----------------------------------------
  // read images
  // ----------------------------------------
  // reserved bits read as zero, whatever the core wrote into them
  function automatic logic [flacu_pkg::DATA_W-1:0] ac_image(
      input logic [flacu_pkg::LAT_W-1:0] lat,
      input logic on,
      input logic active);
    logic [flacu_pkg::DATA_W-1:0] w;
    w = flacu_pkg::ZERO_WORD;
    w[flacu_pkg::AC_LAT_LSB +: flacu_pkg::LAT_W] = lat;
    w[flacu_pkg::AC_PREFETCH_ON_BIT] = on;
    w[flacu_pkg::AC_PREFETCH_ACTIVE_BIT] = active;
    return w;
  endfunction

  always_comb begin
    lat_d = lat_q;
    prefetch_on_d = prefetch_on_q;
    prefetch_active_flag_d = prefetch_on_q;
    ctrl_d = ctrl_q;
    taddr_d = taddr_q;
    rdata_d = rdata_q;
    ack_d = BUS.reg_sel && !ack_q;
    if (wr_en) begin
      if (BUS.reg_addr == flacu_pkg::OFF_ACCESS_CONTROL) begin
        lat_d = BUS.reg_wdata[flacu_pkg::AC_LAT_LSB +: flacu_pkg::LAT_W];
        prefetch_on_d = BUS.reg_wdata[flacu_pkg::AC_PREFETCH_ON_BIT];
      end else if (BUS.reg_addr == flacu_pkg::OFF_UNLOCK_KEY) begin
        if (BUS.reg_wdata == UNLOCK_KEY_VALUE) begin
          ctrl_d[flacu_pkg::CTRL_LOCK_BIT] = 1'b0;
        end
      end else if (BUS.reg_addr == flacu_pkg::OFF_FLASH_CONTROL) begin
        if (!ctrl_q[flacu_pkg::CTRL_LOCK_BIT]) begin
          ctrl_d = BUS.reg_wdata & flacu_pkg::CTRL_WRITABLE;
        end
      end else if (BUS.reg_addr == flacu_pkg::OFF_TARGET_ADDRESS) begin
        taddr_d = BUS.reg_wdata;
      end
    end
    if (BUS.reg_sel && !ack_q) begin
      rdata_d = flacu_pkg::ZERO_WORD;
      if (BUS.reg_addr == flacu_pkg::OFF_ACCESS_CONTROL) begin
        rdata_d = ac_image(lat_q, prefetch_on_q, prefetch_active_flag_q);
      end else if (BUS.reg_addr == flacu_pkg::OFF_UNLOCK_KEY) begin
        rdata_d = flacu_pkg::ZERO_WORD;
      end else if (BUS.reg_addr == flacu_pkg::OFF_FLASH_CONTROL) begin
        rdata_d = ctrl_q;
      end else if (BUS.reg_addr == flacu_pkg::OFF_TARGET_ADDRESS) begin
        rdata_d = taddr_q;
      end else if (BUS.reg_addr == flacu_pkg::OFF_OPTION_BYTE_IMAGE) begin
        rdata_d = OPTION_BYTE_IN;
      end else if (BUS.reg_addr == flacu_pkg::OFF_WRITE_PROTECT_IMAGE) begin
        rdata_d = WRITE_PROTECT_IN;
      end else if (BUS.reg_addr == flacu_pkg::OFF_ECC_VALUE) begin
        rdata_d = ECC_IN;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      lat_q <=
        flacu_pkg::AC_RESET[flacu_pkg::AC_LAT_LSB +: flacu_pkg::LAT_W];
      prefetch_on_q <= flacu_pkg::AC_RESET[flacu_pkg::AC_PREFETCH_ON_BIT];
      prefetch_active_flag_q <=
        flacu_pkg::AC_RESET[flacu_pkg::AC_PREFETCH_ACTIVE_BIT];
      ctrl_q <= flacu_pkg::CTRL_RESET;
      taddr_q <= flacu_pkg::ZERO_WORD;
      rdata_q <= flacu_pkg::ZERO_WORD;
      ack_q <= 1'b0;
    end else begin
      lat_q <= lat_d;
      prefetch_on_q <= prefetch_on_d;
      prefetch_active_flag_q <= prefetch_active_flag_d;
      ctrl_q <= ctrl_d;
      taddr_q <= taddr_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------
  // fetch path
  // ----------------------------------------
  flacu_pkg::flacu_fetch_t fst_q, fst_d;
  logic [flacu_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [flacu_pkg::DATA_W-1:0] faddr_q, faddr_d;
  logic [flacu_pkg::DATA_W-1:0] fdata_q, fdata_d;
  logic fack_q, fack_d;
  logic fvalid_q, fvalid_d;
  logic seq_hit;

  // only a next-word fetch hits; a jump always pays the full latency
  assign seq_hit = prefetch_active_flag_q && fvalid_q &&
                   (BUS.fetch_addr == faddr_q + flacu_pkg::WORD_STEP);

  always_comb begin
    fst_d = fst_q;
    cnt_d = cnt_q;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    fvalid_d = fvalid_q;
    fack_d = 1'b0;
    case (fst_q)
      flacu_pkg::FLACU_F_IDLE: begin
        if (BUS.fetch_req && !fack_q) begin
          faddr_d = BUS.fetch_addr;
          cnt_d = seq_hit ? flacu_pkg::CNT_ZERO : lat_q;
          fst_d = flacu_pkg::FLACU_F_WAIT;
        end
      end
      flacu_pkg::FLACU_F_WAIT: begin
        if (cnt_q == flacu_pkg::CNT_ZERO) begin
          fdata_d = FLASH_RDATA;
          fack_d = 1'b1;
          fvalid_d = 1'b1;
          fst_d = flacu_pkg::FLACU_F_IDLE;
        end else begin
          cnt_d = cnt_q - flacu_pkg::CNT_ONE;
        end
      end
      default: fst_d = flacu_pkg::FLACU_F_IDLE;
    endcase
    if (!prefetch_on_q) begin
      fvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      fst_q <= flacu_pkg::FLACU_F_IDLE;
      cnt_q <= flacu_pkg::CNT_ZERO;
      faddr_q <= flacu_pkg::ZERO_WORD;
      fdata_q <= flacu_pkg::ZERO_WORD;
      fack_q <= 1'b0;
      fvalid_q <= 1'b0;
    end else begin
      fst_q <= fst_d;
      cnt_q <= cnt_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      fack_q <= fack_d;
      fvalid_q <= fvalid_d;
    end
  end

  assign BUS.reg_rdata = rdata_q;
  assign BUS.reg_ack = ack_q;
  assign BUS.fetch_rdata = fdata_q;
  assign BUS.fetch_ack = fack_q;
  assign FLASH_ADDR = faddr_q;
  assign CTRL_FIELDS = ctrl_q;
  assign LOCKED = ctrl_q[flacu_pkg::CTRL_LOCK_BIT];
  assign PREFETCH_ACTIVE = prefetch_active_flag_q;
endmodule

// [tb/flacu_monitor.sv]
`timescale 1ns/1ps
module flacu_monitor #(
  parameter logic [flacu_pkg::DATA_W-1:0] UNLOCK_KEY_VALUE =
    flacu_pkg::UNLOCK_KEY_DEFAULT
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [flacu_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flacu_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [flacu_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic fetch_req,
  input wire logic fetch_ack
);
  // ----------------------------------------
  // shadow of settings seen on the bus
  // ----------------------------------------
  logic wt;
  logic [1:0] lat_d, lat_q;
  logic pf_d, pf_q;
  logic [31:0] ctl_d, ctl_q;
  assign wt = reg_sel && !reg_ack && reg_wr;
  always_comb begin
    lat_d = lat_q;
    pf_d = pf_q;
    ctl_d = ctl_q;
    if (wt && reg_addr == flacu_pkg::OFF_ACCESS_CONTROL) begin
      lat_d = reg_wdata[1:0];
      pf_d = reg_wdata[4];
    end
    if (wt && reg_addr == flacu_pkg::OFF_UNLOCK_KEY &&
        reg_wdata == UNLOCK_KEY_VALUE) begin
      ctl_d = ctl_q & ~32'h0000_0080;
    end
    // locked control ignores writes
    if (wt && reg_addr == flacu_pkg::OFF_FLASH_CONTROL && !ctl_q[7]) begin
      ctl_d = reg_wdata & flacu_pkg::CTRL_WRITABLE;
    end
  end
  always_ff @(posedge CLK) begin
    lat_q <= SRST ? 2'h0 : lat_d;
    pf_q <= SRST ? 1'b1 : pf_d;
    ctl_q <= SRST ? flacu_pkg::CTRL_RESET : ctl_d;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_rd(logic [7:0] a);
    reg_sel && !reg_ack && !reg_wr && reg_addr == a;
  endsequence
  sequence s_w0;
    !fetch_ack ##1 !fetch_ack ##1 fetch_ack;
  endsequence
  sequence s_w1;
    !fetch_ack [*3] ##1 fetch_ack;
  endsequence
  property p_ack;
    reg_sel && !reg_ack |=> reg_ack ##1 !reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("reg ack timing");
  property p_key;
    s_rd(flacu_pkg::OFF_UNLOCK_KEY) |=> reg_rdata == 32'h0;
  endproperty
  a_key: assert property (p_key) else $error("key readback");
  // status beside enable
  // status lags the enable by one cycle; reads come later than that
  property p_ac;
    s_rd(flacu_pkg::OFF_ACCESS_CONTROL) |=>
      reg_rdata == {26'h0, pf_q, pf_q, 2'h0, lat_q};
  endproperty
  a_ac: assert property (p_ac) else $error("access ctl read");
  property p_ctl;
    s_rd(flacu_pkg::OFF_FLASH_CONTROL) |=> reg_rdata == ctl_q;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_f0;
    $rose(fetch_req) && !pf_q && lat_q == 2'h0 |-> s_w0;
  endproperty
  a_f0: assert property (p_f0) else $error("zero wait fetch");
  property p_f1;
    $rose(fetch_req) && !pf_q && lat_q == 2'h1 |-> s_w1;
  endproperty
  a_f1: assert property (p_f1) else $error("one wait fetch");
  property p_fpf;
    $rose(fetch_req) && pf_q |-> ##[2:3] fetch_ack;
  endproperty
  a_fpf: assert property (p_fpf) else $error("prefetch fetch");
  property p_fpl;
    fetch_ack |=> !fetch_ack;
  endproperty
  a_fpl: assert property (p_fpl) else $error("fetch ack pulse");
endmodule

// [tb/flash_access_ctrl_unlock_tb.sv]
`timescale 1ns/1ps
module flash_access_ctrl_unlock_tb;
  // arbitrary key, not tied to any part
  localparam logic [31:0] KEY = 32'h1357_9BDF;
  localparam logic [31:0] PAT = 32'hC3C3_0000;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic cv = 1'b0;
  logic cw = 1'b0;
  logic cf = 1'b0;
  logic [7:0] ca = 8'h00;
  logic [31:0] cd = 32'h0;
  logic crdy, cdone, lkd, pfa;
  logic [31:0] crd, fad, ctf, rd;
  int n, n0, n1, n2, mismatches, num_checks;
  always #5 CLK = ~CLK;
  flacu_if i_flacu_if();
  flacu_core i_flacu_core (.CLK(CLK), .SRST(SRST), .BUS(i_flacu_if),
    .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_FETCH(cf), .CMD_ADDR(ca),
    .CMD_WDATA(cd), .CMD_READY(crdy), .CMD_RDATA(crd), .CMD_DONE(cdone));
  flacu_dev #(.UNLOCK_KEY_VALUE(KEY)) i_flacu_dev (.CLK(CLK), .SRST(SRST),
    .BUS(i_flacu_if), .FLASH_RDATA(fad ^ PAT), .OPTION_BYTE_IN(32'h0000_1111),
    .WRITE_PROTECT_IN(32'h0000_2222), .ECC_IN(32'h0000_0033),
    .FLASH_ADDR(fad), .CTRL_FIELDS(ctf), .LOCKED(lkd), .PREFETCH_ACTIVE(pfa));
  flacu_monitor #(.UNLOCK_KEY_VALUE(KEY)) i_flacu_monitor (.CLK(CLK),
    .SRST(SRST), .reg_sel(i_flacu_if.reg_sel), .reg_wr(i_flacu_if.reg_wr),
    .reg_addr(i_flacu_if.reg_addr), .reg_wdata(i_flacu_if.reg_wdata),
    .reg_rdata(i_flacu_if.reg_rdata), .reg_ack(i_flacu_if.reg_ack),
    .fetch_req(i_flacu_if.fetch_req), .fetch_ack(i_flacu_if.fetch_ack));
  // ----------------------------------------
  // command tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // n ends as the cycle count to done, used for latency comparisons
  task automatic cmd(input logic w, input logic f, input logic [7:0] a,
      input logic [31:0] d);
    {cv, cw, cf, ca, cd} = {1'b1, w, f, a, d};
    n = 0;
    while (crdy !== 1'b1 && n < 20) begin
      @(posedge CLK);
      #1;
      n++;
    end
    @(posedge CLK);
    #1;
    cv = 1'b0;
    n = 0;
    while (cdone !== 1'b1 && n < 40) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk("cmd done", 32'h1, {31'h0, cdone});
    rd = crd;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    cmd(1'b0, 1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic fch(input logic [31:0] a);
    cmd(1'b0, 1'b1, 8'h00, a);
    chk("fetch data", a ^ PAT, rd);
    chk("fetch addr", a, fad);
  endtask
  initial begin
    #5000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge CLK);
    #1;
    SRST = 1'b0;
    rdc("ac reset", 8'h00, 32'h0000_0030);
    rdc("ctl reset", 8'h10, 32'h0000_0080);
    chk("locked reset", 32'h1, {31'h0, lkd});
    chk("pf port reset", 32'h1, {31'h0, pfa});
    rdc("key read", 8'h04, 32'h0);
    rdc("ob", 8'h1C, 32'h0000_1111);
    rdc("wrp", 8'h20, 32'h0000_2222);
    rdc("ecc", 8'h24, 32'h0000_0033);
    rdc("unmapped", 8'h40, 32'h0);
    cmd(1'b1, 1'b0, 8'h10, 32'h0000_0001);
    rdc("ctl locked", 8'h10, 32'h0000_0080);
    cmd(1'b1, 1'b0, 8'h04, KEY ^ 32'h1);
    chk("bad key", 32'h1, {31'h0, lkd});
    cmd(1'b1, 1'b0, 8'h04, KEY);
    chk("good key", 32'h0, {31'h0, lkd});
    rdc("key read open", 8'h04, 32'h0);
    cmd(1'b1, 1'b0, 8'h10, 32'h0000_1003);
    rdc("ctl open", 8'h10, 32'h0000_1003);
    chk("ctl port", 32'h0000_1003, ctf);
    cmd(1'b1, 1'b0, 8'h10, 32'h0000_0080);
    cmd(1'b1, 1'b0, 8'h10, 32'h0000_0000);
    rdc("relocked", 8'h10, 32'h0000_0080);
    cmd(1'b1, 1'b0, 8'h14, 32'h0000_ABC4);
    rdc("target", 8'h14, 32'h0000_ABC4);
    cmd(1'b1, 1'b0, 8'h00, 32'h0000_0000);
    rdc("pf off", 8'h00, 32'h0000_0000);
    chk("pf port", 32'h0, {31'h0, pfa});
    fch(32'h0000_0100);
    n0 = n;
    chk("zero wait", 32'h3, n0);
    cmd(1'b1, 1'b0, 8'h00, 32'h0000_0001);
    rdc("lat one", 8'h00, 32'h0000_0001);
    fch(32'h0000_0200);
    n1 = n;
    chk("one wait", n0 + 1, n1);
    cmd(1'b1, 1'b0, 8'h00, 32'h0000_0011);
    rdc("pf on", 8'h00, 32'h0000_0031);
    chk("pf port on", 32'h1, {31'h0, pfa});
    fch(32'h0000_0300);
    fch(32'h0000_0304);
    n2 = n;
    chk("pf hit", n0, n2);
    cmd(1'b1, 1'b0, 8'h00, 32'h0000_0013);
    rdc("lat clamp", 8'h00, 32'h0000_0031);
    tally_and_finish();
  end
endmodule
